// ---- design/hisq_core.sv ----
// hot insertion sequencer: debounce, breaker, supply good, reset timing
// Summary of operation
// RULE1 - both sense lows for 20 ms mean inserted
// RULE2 - hard reset low 20 ms: supplies off
// RULE3 - no power-up while hard reset low
// RULE4 - wait for discharged level before power-up
// RULE5 - hard reset low clears breaker trip
// RULE6 - fault low while overcurrent latched
// RULE7 - supply good follows monitor immediately; the code also holds it low while tripped
// RULE8 - reset low on any listed condition
// RULE9 - reset released 200 ms after supply good
// RULE10 - reset low 32 us after supply good falls
// RULE11 - pump status mirrors charge pump enable
// RULE12 - bus isolate during insertion and removal
// RULE13 - overcurrent over 20 us trips breaker
// RULE14 - trip pulls both gates down at once
// RULE15 - pumps off until both supplies unlocked
// RULE16 - gates low at power-up until inserted
// RULE17 - after debounce enable ramp and pumps
// RULE18 - power-down enables gate pull-down path
// RULE19 - short supply good pulses leave reset
// RULE20 - trip latched until hard reset or power
// RULE21 - counters on one clock, inputs synchronised
module hisq_core
   import hisq_pkg::*;
#(
   parameter int unsigned CYC_PER_US = CLK_MHZ,
   parameter int unsigned INSERT_CYC = INSERT_MS * US_PER_MS * CYC_PER_US,
   parameter int unsigned HRST_CYC = HARD_RESET_MS * US_PER_MS * CYC_PER_US,
   parameter int unsigned REL_CYC = RESET_REL_MS * US_PER_MS * CYC_PER_US
)
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // connector and comparator inputs
   input wire logic connect_sense_a_n_i,
   input wire logic connect_sense_b_n_i,
   input wire logic hard_reset_n_i,
   input wire logic uvlo_lo_ok_i,
   input wire logic uvlo_hi_ok_i,
   input wire logic supply_above_i,
   input wire logic low_sense_input_i,
   input wire logic high_sense_input_i,
   input wire logic discharged_level_i,
   // open-drain style outputs, shown as driven levels with enables
   output logic fault_n_o,
   output logic fault_n_oe_o,
   output logic supply_good_o,
   output logic supply_good_oe_o,
   output logic reset_n_o,
   output logic reset_n_oe_o,
   // cmos outputs
   output logic bus_isolate_o,
   output logic pump_on_status_o,
   output logic ramp_enable_o,
   output logic high_gate_drive_o,
   output logic low_gate_drive_o,
   output logic gate_pulldown_o
);
   localparam int unsigned ASRT_CYC = RESET_ASRT_US * CYC_PER_US;
   localparam int unsigned TRIP_CYC = BREAKER_US * CYC_PER_US;
   localparam logic [CNT_W-1:0] INSERT_N = CNT_W'(INSERT_CYC);
   localparam logic [CNT_W-1:0] HRST_N = CNT_W'(HRST_CYC);
   localparam logic [CNT_W-1:0] REL_N = CNT_W'(REL_CYC);
   localparam logic [CNT_W-1:0] ASRT_N = CNT_W'(ASRT_CYC);
   localparam logic [CNT_W-1:0] TRIP_N = CNT_W'(TRIP_CYC);

   hisq_sync_if sync ();
   hisq_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .raw_i({discharged_level_i, high_sense_input_i, low_sense_input_i,
         supply_above_i, uvlo_hi_ok_i, uvlo_lo_ok_i, hard_reset_n_i,
         connect_sense_b_n_i, connect_sense_a_n_i}),
      .sync(sync.src)
   );

   ////////////////////////////////////////////////////////////////////////
   // debounce and delay counters
   logic [CNT_W-1:0] ins_cnt;
   logic [CNT_W-1:0] hrst_cnt;
   logic [CNT_W-1:0] oc_cnt;
   logic [CNT_W-1:0] rel_cnt;
   logic [CNT_W-1:0] asrt_cnt;
   logic inserted;
   logic hard_reset;
   logic oc_trip;
   logic both_low;
   hisq_state_t state;
   hisq_state_t next_state;

   assign both_low = !sync.sense_a_n && !sync.sense_b_n;
   assign inserted = (ins_cnt == INSERT_N);
   assign hard_reset = (hrst_cnt == HRST_N);
   assign oc_trip = (oc_cnt == TRIP_N);

   // saturating count of continuous both-low time
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || !both_low) begin
         ins_cnt <= CNT_ZERO;
      end else if (!inserted) begin
         ins_cnt <= ins_cnt + CNT_ONE; // RULE1
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || sync.hard_reset_n) begin
         hrst_cnt <= CNT_ZERO;
      end else if (!hard_reset) begin
         hrst_cnt <= hrst_cnt + CNT_ONE; // RULE2
      end
   end

   // count must exceed 20 us; trip fires when the count reaches the figure
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || !sync.oc_any) begin
         oc_cnt <= CNT_ZERO;
      end else if (!oc_trip) begin
         oc_cnt <= oc_cnt + CNT_ONE; // RULE13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      next_state = state;
      case (state)
         HISQ_ST_LOCKOUT: begin
            if (sync.uvlo_ok) begin
               next_state = HISQ_ST_WAIT_INSERT; // RULE15
            end
         end
         HISQ_ST_WAIT_INSERT: begin
            // RULE3 RULE4
            // both_low again so a sense break on this edge cannot start pumps
            if (inserted && both_low && sync.hard_reset_n
               && sync.discharged_level) begin
               next_state = HISQ_ST_RAMP; // RULE17
            end
         end
         HISQ_ST_RAMP: begin
            if (oc_trip) begin
               next_state = HISQ_ST_TRIPPED; // RULE14
            end else if (hard_reset || !both_low) begin
               next_state = HISQ_ST_DISCHARGE; // RULE2
            end
         end
         HISQ_ST_DISCHARGE: begin
            next_state = HISQ_ST_WAIT_INSERT; // RULE18
         end
         HISQ_ST_TRIPPED: begin
            if (!sync.hard_reset_n) begin
               next_state = HISQ_ST_WAIT_INSERT; // RULE5 RULE20
            end
         end
         default: begin
            next_state = HISQ_ST_LOCKOUT;
         end
      endcase
      // lockout overrides everything, also clears a trip on power cycle
      if (!sync.uvlo_ok) begin
         next_state = HISQ_ST_LOCKOUT; // RULE15 RULE20
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state <= HISQ_ST_LOCKOUT; // RULE16
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // supply good and reset timing
   logic good;
   logic rst_cond;
   assign good = sync.supply_above && (state != HISQ_ST_TRIPPED);
   // RULE8
   assign rst_cond = sync.sense_a_n || sync.sense_b_n
      || !sync.hard_reset_n || !sync.uvlo_ok
      || (state == HISQ_ST_TRIPPED);

   // high time of good; short low pulses restart it
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || !good) begin
         rel_cnt <= CNT_ZERO;
      end else if (rel_cnt != REL_N) begin
         rel_cnt <= rel_cnt + CNT_ONE; // RULE9 RULE19
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || good) begin
         asrt_cnt <= CNT_ZERO;
      end else if (asrt_cnt != ASRT_N) begin
         asrt_cnt <= asrt_cnt + CNT_ONE; // RULE10 RULE19
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         reset_n_o <= 1'b0;
      end else if (rst_cond) begin
         reset_n_o <= 1'b0; // RULE8
      end else if (asrt_cnt == ASRT_N) begin
         reset_n_o <= 1'b0; // RULE10
      end else if (rel_cnt == REL_N) begin
         reset_n_o <= 1'b1; // RULE9
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         supply_good_o <= 1'b0;
         fault_n_o <= 1'b1;
      end else begin
         supply_good_o <= good; // RULE7
         fault_n_o <= (state != HISQ_ST_TRIPPED); // RULE6
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // gate, pump and bus controls
   logic pumps_on;
   assign pumps_on = (next_state == HISQ_ST_RAMP);
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         pump_on_status_o <= 1'b0;
         ramp_enable_o <= 1'b0;
         high_gate_drive_o <= 1'b0;
         low_gate_drive_o <= 1'b0;
         gate_pulldown_o <= 1'b1;
         bus_isolate_o <= 1'b1;
      end else begin
         pump_on_status_o <= pumps_on; // RULE11
         ramp_enable_o <= pumps_on; // RULE17
         high_gate_drive_o <= pumps_on; // RULE14 RULE16
         low_gate_drive_o <= pumps_on; // RULE14 RULE16
         gate_pulldown_o <= !pumps_on; // RULE18
         bus_isolate_o <= !pumps_on || !reset_n_o; // RULE12
      end
   end

   // open-drain enables: drive only while pulling low
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         fault_n_oe_o <= 1'b0;
         supply_good_oe_o <= 1'b1;
         reset_n_oe_o <= 1'b1;
      end else begin
         fault_n_oe_o <= (state == HISQ_ST_TRIPPED);
         supply_good_oe_o <= !good;
         reset_n_oe_o <= rst_cond || (asrt_cnt == ASRT_N)
            || (!reset_n_o && rel_cnt != REL_N);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_fault_tracks_trip: assert property (@(posedge clk_sys_i) // RULE6
      disable iff (!resetn_i) (state == HISQ_ST_TRIPPED) |=> !fault_n_o)
      else $error("fault not low while tripped");
   a_trip_kills_gates: assert property (@(posedge clk_sys_i) // RULE14
      disable iff (!resetn_i) (state == HISQ_ST_RAMP && oc_trip)
      |=> !high_gate_drive_o && !low_gate_drive_o)
      else $error("gates not cut on trip");
   a_trip_latched: assert property (@(posedge clk_sys_i) // RULE20
      disable iff (!resetn_i) (state == HISQ_ST_TRIPPED
      && sync.hard_reset_n && sync.uvlo_ok) |=> state == HISQ_ST_TRIPPED)
      else $error("trip released early");
   a_no_start_hrst: assert property (@(posedge clk_sys_i) // RULE3
      disable iff (!resetn_i) !sync.hard_reset_n |=> !pump_on_status_o
      || $past(state) == HISQ_ST_RAMP)
      else $error("power-up during hard reset");
   a_wait_discharge: assert property (@(posedge clk_sys_i) // RULE4
      disable iff (!resetn_i) (state == HISQ_ST_WAIT_INSERT
      && !sync.discharged_level) |=> state != HISQ_ST_RAMP)
      else $error("started before discharge");
   a_lockout_pumps: assert property (@(posedge clk_sys_i) // RULE15
      disable iff (!resetn_i) !sync.uvlo_ok |=> !pump_on_status_o)
      else $error("pumps on in lockout");
   a_good_follows: assert property (@(posedge clk_sys_i) // RULE7
      disable iff (!resetn_i) 1'b1 |=> supply_good_o == $past(good))
      else $error("supply good lags");
   a_reset_cond: assert property (@(posedge clk_sys_i) // RULE8
      disable iff (!resetn_i) rst_cond |=> !reset_n_o)
      else $error("reset not asserted");
   a_pump_status: assert property (@(posedge clk_sys_i) // RULE11 RULE18
      disable iff (!resetn_i) pump_on_status_o == high_gate_drive_o
      && pump_on_status_o == !gate_pulldown_o)
      else $error("pump status mismatch");
   a_insert_start: assert property (@(posedge clk_sys_i) // RULE1 RULE17
      disable iff (!resetn_i) $rose(pump_on_status_o) |-> inserted)
      else $error("pumps on before debounce");
   a_release_delay: assert property (@(posedge clk_sys_i) // RULE9
      disable iff (!resetn_i) $rose(reset_n_o) |-> $past(rel_cnt) == REL_N)
      else $error("reset released early");
   a_short_low: assert property (@(posedge clk_sys_i) // RULE10 RULE19
      disable iff (!resetn_i) reset_n_o && !rst_cond && asrt_cnt != ASRT_N
      |=> reset_n_o)
      else $error("reset dropped by short low");
   a_bus_isolate: assert property (@(posedge clk_sys_i) // RULE12
      disable iff (!resetn_i) !pump_on_status_o |-> bus_isolate_o)
      else $error("bus not isolated with pumps off");
   a_breaker_time: assert property (@(posedge clk_sys_i) // RULE13
      disable iff (!resetn_i) (state == HISQ_ST_RAMP && !oc_trip)
      |=> state != HISQ_ST_TRIPPED)
      else $error("breaker tripped early");
   c_ramp: cover property (@(posedge clk_sys_i) state == HISQ_ST_RAMP);
   c_trip: cover property (@(posedge clk_sys_i) state == HISQ_ST_TRIPPED);
   c_release: cover property (@(posedge clk_sys_i) $rose(reset_n_o));
   c_hrst: cover property (@(posedge clk_sys_i) hard_reset);
   c_discharge: cover property (@(posedge clk_sys_i)
      state == HISQ_ST_DISCHARGE);
endmodule : hisq_core

// ---- design/hisq_pkg.sv ----
// constants and types for the hot insertion sequencer
package hisq_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned INSERT_MS = 20;
   localparam int unsigned HARD_RESET_MS = 20;
   localparam int unsigned RESET_REL_MS = 200;
   localparam int unsigned RESET_ASRT_US = 32;
   localparam int unsigned BREAKER_US = 20;
   localparam int unsigned US_PER_MS = 1000;
   localparam int unsigned CNT_W = 26;
   localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 26'h1;
   localparam int unsigned N_SENSE = 2;
   // raw input bit positions and their disconnected reset pattern
   localparam int unsigned RAW_W = 9;
   localparam int unsigned RAW_SA = 0;
   localparam int unsigned RAW_SB = 1;
   localparam int unsigned RAW_HRST = 2;
   localparam int unsigned RAW_UV_LO = 3;
   localparam int unsigned RAW_UV_HI = 4;
   localparam int unsigned RAW_ABOVE = 5;
   localparam int unsigned RAW_OC_LO = 6;
   localparam int unsigned RAW_OC_HI = 7;
   localparam int unsigned RAW_DISCH = 8;
   localparam logic [RAW_W-1:0] RAW_IDLE = 9'h007;
   typedef enum logic [2:0] {
      HISQ_ST_LOCKOUT = 3'b000,
      HISQ_ST_WAIT_INSERT = 3'b001,
      HISQ_ST_RAMP = 3'b010,
      HISQ_ST_DISCHARGE = 3'b011,
      HISQ_ST_TRIPPED = 3'b100
   } hisq_state_t;
endpackage : hisq_pkg

// ---- design/hisq_sync_if.sv ----
// interface carrying synchronised inputs to the core
interface hisq_sync_if;
   logic sense_a_n;
   logic sense_b_n;
   logic hard_reset_n;
   logic uvlo_ok;
   logic supply_above;
   logic oc_any;
   logic discharged_level;
   modport src (output sense_a_n, sense_b_n, hard_reset_n, uvlo_ok,
      supply_above, oc_any, discharged_level);
   modport dst (input sense_a_n, sense_b_n, hard_reset_n, uvlo_ok,
      supply_above, oc_any, discharged_level);
endinterface : hisq_sync_if

// ---- design/hisq_sync.sv ----
// two-flop synchronisers for every asynchronous input
module hisq_sync
   import hisq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // raw inputs, order: sense a, sense b, hard reset, uvlo lo, uvlo hi,
   // supply above, oc lo, oc hi, discharged
   input wire logic [8:0] raw_i,
   hisq_sync_if.src sync
);
   logic [RAW_W-1:0] stage1;
   logic [RAW_W-1:0] stage2;
   // resets to the safe, disconnected values
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         stage1 <= RAW_IDLE;
         stage2 <= RAW_IDLE;
      end else begin
         stage1 <= raw_i; // RULE21
         stage2 <= stage1;
      end
   end
   assign sync.sense_a_n = stage2[RAW_SA];
   assign sync.sense_b_n = stage2[RAW_SB];
   assign sync.hard_reset_n = stage2[RAW_HRST];
   assign sync.uvlo_ok = stage2[RAW_UV_LO] & stage2[RAW_UV_HI];
   assign sync.supply_above = stage2[RAW_ABOVE];
   assign sync.oc_any = stage2[RAW_OC_LO] | stage2[RAW_OC_HI];
   assign sync.discharged_level = stage2[RAW_DISCH];
endmodule : hisq_sync

// ---- tb/hisq_conn_model.sv ----
// backplane connector model: staggered sense pins and host hard reset
module hisq_conn_model (
   // clock
   input wire logic clk_sys_i,
   // commands from the bench
   input wire logic seated_i,
   input wire logic hold_n_i,
   // connector pins toward the board
   output logic sense_a_n_o = 1'b1,
   output logic sense_b_n_o = 1'b1,
   output logic hard_reset_n_o = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   // host grounds the sense pins; unmated pins float up to the pull-up
   // b mates one cycle after a, both break together on removal
   always @(posedge clk_sys_i) begin
      sense_a_n_o <= ~seated_i;
      sense_b_n_o <= sense_a_n_o | ~seated_i;
      hard_reset_n_o <= hold_n_i;
   end
endmodule : hisq_conn_model

// ---- tb/tb_hot_insertion_sequencer.sv ----
// self-checking bench for the hot insertion sequencer core
module tb_hot_insertion_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   // short counts keep the run brief
   localparam int CPU = 2;
   localparam int INS = 100;
   localparam int HRS = 100;
   localparam int REL = 200;
   localparam int BRK = hisq_pkg::BREAKER_US * CPU;
   localparam int AST = hisq_pkg::RESET_ASRT_US * CPU;
   localparam int PMP = 0, FLT = 1, GD = 2, RST = 3, ISO = 4, PD = 5;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic seated = 1'b0, hold_n = 1'b1, uv_lo = 1'b1, uv_hi = 1'b1;
   logic above = 1'b0, oc_lo = 1'b0, oc_hi = 1'b0, disch = 1'b1;
   logic sa, sb, hr, flt, gd, rst, iso, pmp, rmp, hg, lg, pd;
   logic foe, goe, roe;
   logic [5:0] obs;
   int err_total = 0;
   int total_checks = 0;
   int r;
   assign obs = {pd, iso, rst, gd, flt, pmp};
   hisq_conn_model i_conn (.clk_sys_i(clk_sys_i), .seated_i(seated),
      .hold_n_i(hold_n), .sense_a_n_o(sa), .sense_b_n_o(sb),
      .hard_reset_n_o(hr));
   hisq_core #(.CYC_PER_US(CPU), .INSERT_CYC(INS), .HRST_CYC(HRS),
      .REL_CYC(REL)) i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .connect_sense_a_n_i(sa), .connect_sense_b_n_i(sb),
      .hard_reset_n_i(hr), .uvlo_lo_ok_i(uv_lo), .uvlo_hi_ok_i(uv_hi),
      .supply_above_i(above), .low_sense_input_i(oc_lo),
      .high_sense_input_i(oc_hi), .discharged_level_i(disch),
      .fault_n_o(flt), .fault_n_oe_o(foe), .supply_good_o(gd),
      .supply_good_oe_o(goe), .reset_n_o(rst), .reset_n_oe_o(roe),
      .bus_isolate_o(iso), .pump_on_status_o(pmp), .ramp_enable_o(rmp),
      .high_gate_drive_o(hg), .low_gate_drive_o(lg),
      .gate_pulldown_o(pd));
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   // open-drain enables drive exactly while the level is low
   always @(negedge clk_sys_i) begin
      if ({foe, goe, roe} !== ~{flt, gd, rst}) begin
         err_total++;
         $display("unexpected at %0t: open-drain enable", $time);
      end
   end
   ///////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %b want %b", $time, got, exp);
      end
   endtask : chk
   // event on obs bit must land between lo and hi cycles; lo > hi: never
   task automatic ev(input int idx, input logic v, input int lo, hi);
      int n;
      n = 0;
      while (obs[idx] !== v && n <= hi) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      total_checks++;
      if (n < lo || (n > hi && lo <= hi)) begin
         err_total++;
         $display("unexpected at %0t: bit %0d after %0d", $time, idx, n);
      end
   endtask : ev
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc
   // a low spell drops reset once it reaches the assert delay
   function automatic bit rst_drops(input int low_cyc);
      return low_cyc >= AST;
   endfunction : rst_drops
   ///////////////////////////////////////////////////////////////////////
   initial begin
      cyc(20000);
      err_total++;
      final_report();
   end
   initial begin
      void'($urandom(4283));
      cyc(10);
      #1;
      chk(obs, 6'b110010);
      @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      seated <= 1'b1;
      ev(PMP, 1, INS - 2, INS + 10);
      chk({rmp, hg, lg, pd}, 4'b1110);
      @(posedge clk_sys_i);
      above <= 1'b1;
      ev(GD, 1, 0, 4);
      ev(RST, 1, REL - 4, REL + 10);
      r = 5 + $urandom % 40;
      @(posedge clk_sys_i);
      above <= 1'b0;
      ev(GD, 0, 0, 4);
      cyc(r);
      above <= 1'b1;
      ev(RST, 0, rst_drops(r + 3) ? 0 : 101, 100);
      @(posedge clk_sys_i);
      above <= 1'b0;
      ev(RST, 0, AST - 4, AST + 8);
      @(posedge clk_sys_i);
      above <= 1'b1;
      cyc(50);
      above <= 1'b0;
      ev(RST, 1, 101, 100);
      @(posedge clk_sys_i);
      above <= 1'b1;
      ev(RST, 1, REL - 4, REL + 10);
      for (int i = 0; i < 4; i++) begin
         r = 5 + $urandom % (BRK - 10);
         @(posedge clk_sys_i);
         if (i[0]) begin
            oc_hi <= 1'b1;
         end else begin
            oc_lo <= 1'b1;
         end
         cyc(r);
         oc_hi <= 1'b0;
         oc_lo <= 1'b0;
         ev(FLT, 0, 61, 60);
      end
      @(posedge clk_sys_i);
      oc_hi <= 1'b1;
      ev(FLT, 0, BRK - 2, BRK + 8);
      ev(PMP, 0, 0, 2);
      ev(RST, 0, 0, AST + 8);
      @(posedge clk_sys_i);
      oc_hi <= 1'b0;
      ev(FLT, 1, 31, 30);
      @(posedge clk_sys_i);
      hold_n <= 1'b0;
      ev(FLT, 1, 0, 6);
      @(posedge clk_sys_i);
      hold_n <= 1'b1;
      ev(PMP, 1, 2, 8);
      @(posedge clk_sys_i);
      disch <= 1'b0;
      hold_n <= 1'b0;
      ev(PMP, 0, HRS - 2, HRS + 10);
      chk(pd, 1'b1);
      ev(PMP, 1, 51, 50);
      @(posedge clk_sys_i);
      hold_n <= 1'b1;
      ev(PMP, 1, 101, 100);
      @(posedge clk_sys_i);
      disch <= 1'b1;
      ev(PMP, 1, 0, INS + 12);
      @(posedge clk_sys_i);
      seated <= 1'b0;
      ev(PMP, 0, 0, 5);
      cyc(2);
      chk({iso, rst}, 2'b10);
      seated <= 1'b1;
      ev(PMP, 1, INS - 2, INS + 12);
      @(posedge clk_sys_i);
      uv_lo <= 1'b0;
      ev(PMP, 0, 0, 5);
      ev(PMP, 1, 101, 100);
      final_report();
   end
endmodule : tb_hot_insertion_sequencer
